// File: sfh_pkg.sv
/*
 * Shared constants and types for both ends of the serial flash link.
 * Assumes a 200 MHz core clock on each end.
 */
package sfh_pkg;
    localparam logic [7:0] OP_READ_FAST = 8'h0B;
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_READ_LEGACY = 8'hE8;
    localparam logic [7:0] OP_PROT_RD = 8'h32;
    localparam logic [7:0] OP_LOCK_RD = 8'h35;
    localparam logic [7:0] OP_SEC_RD = 8'h77;
    localparam logic [7:0] OP_ID_RD = 8'h9F;

    localparam logic [2:0] ADDR_BYTES = 3'h3;
    localparam logic [2:0] DUMMY_FAST = 3'h1;
    localparam logic [2:0] DUMMY_LEGACY = 3'h4;
    localparam logic [2:0] DUMMY_NONE = 3'h0;

    localparam int ADDR_W = 24;
    localparam int PAGE_LSB = 10;
    localparam logic [9:0] PAGE_LAST_LONG = 10'h20F;
    localparam logic [2:0] ID_LEN = 3'h4;

    localparam int CORE_MHZ = 200;
    localparam int CORE_PERIOD_NS = 5;
    localparam int SCK_FMAX_MHZ = 66;
    localparam int SCK_BENCH_PERIOD_NS = 160;
    localparam int SCK_MIN_HALF_CYC = (CORE_MHZ + 2 * SCK_FMAX_MHZ - 1) / (2 * SCK_FMAX_MHZ);
    localparam int SCK_HALF_CYC = SCK_BENCH_PERIOD_NS / (2 * CORE_PERIOD_NS);

    localparam int REFRESH_OPS = 10000;
    localparam int PAGES_PER_SECTOR = 256;
    localparam int OPS_PER_REFRESH = REFRESH_OPS / PAGES_PER_SECTOR;

    typedef enum logic [1:0] {
        SRC_ARRAY = 2'h0,
        SRC_PROT = 2'h1,
        SRC_LOCK = 2'h2,
        SRC_SEC = 2'h3
    } sfh_src_e;
endpackage

// File: sfh_link_if.sv
/*
 * Serial link between flash host and flash device.
 * Assumes the output line is pulled high when the device does not drive it.
 */
`timescale 1ns/1ps
interface sfh_link_if;
    logic sck;
    logic cs_n;
    logic si;
    logic rst_n;
    logic so_drv;
    logic so_oe;
    logic so_wire;

    // Pull-up on the shared output line
    assign so_wire = so_oe ? so_drv : 1'b1;

    modport dev (input sck, input cs_n, input si, input rst_n, output so_drv, output so_oe);
    modport host (output sck, output cs_n, output si, output rst_n, input so_wire);
endinterface

// File: sfh_dev.sv
/*
 * Device end of the serial flash link: opcode decode, address and dummy
 * phases, and serial read-out of array, register and identification bytes.
 * Assumes the serial clock half period is at least six core cycles and the
 * user side answers a byte request on the cycle after it.
 */
`timescale 1ns/1ps
// How it works
// - Accept mode 0 or mode 3 idle clock
// - SPI modes: output valid within low phase
// - Full-cycle modes: output may settle later
// - Shift out on fall, sample on rise
// - Host captures output at next fall
// - Host launches input bits on rising edge
// - Host keeps select high across reset release
// - Rewrite every page within 10000 operations
// - Host page pointer addresses each rewrite
// - Decode 0B, 03, E8 as array reads
// - Decode 32, 35, 77 as register reads
// - Decode 9F as identification read
// - Page size 528 by default, 512 selectable
// - Page programmed directly or via buffer
module sfh_dev
    import sfh_pkg::*;
#(
    parameter logic PAGE512_SHIPPED = 1'b0,
    // Arbitrary identification bytes, first byte in the top lane
    parameter logic [31:0] ID_BYTES = 32'h5A01_0200
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    sfh_link_if.dev link,
    input wire logic full_cycle_in,
    input wire logic set_512_in,
    input wire logic [7:0] user_data_in,
    output logic user_req_out,
    output sfh_src_e user_src_out,
    output logic [ADDR_W-1:0] user_addr_out,
    output logic page_512_out,
    output logic [7:0] opcode_out,
    output logic opcode_valid_out
);
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_OPC = 3'b001,
        D_ADDR = 3'b011,
        D_DUMMY = 3'b010,
        D_DATA = 3'b110,
        D_SKIP = 3'b111
    } sfh_dst_e;

    sfh_dst_e state;
    logic sck_m, sck_s, sck_d, cs_m, cs_s, si_m, si_s, rst_m, rst_s;
    logic active, rise, fall, byte_done, enter_data, fetch, load;
    logic [2:0] bit_cnt, out_cnt, byte_cnt, dummy_n;
    logic [7:0] shift_in, in_byte, out_shift;
    logic id_mode;
    logic so_q, so_d;

    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a, input logic p512);
        logic [ADDR_W-1:0] r;
        r = ADDR_W'(a + 1'b1);
        if (!p512 && a[PAGE_LSB-1:0] == PAGE_LAST_LONG) begin
            r = {a[ADDR_W-1:PAGE_LSB] + 1'b1, 10'h000};
        end
        return r;
    endfunction

    function automatic logic [7:0] id_byte(input logic [ADDR_W-1:0] idx);
        logic [7:0] r;
        r = 8'h00;
        if (idx < ADDR_W'(ID_LEN)) begin
            r = ID_BYTES[8'(31 - 8 * idx[1:0]) -: 8];
        end
        return r;
    endfunction

    // Two-flop synchronisers for all link inputs
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            {sck_m, sck_s, cs_m, cs_s, si_m, si_s, rst_m, rst_s} <= 8'h30;
            sck_d <= 1'b0;
        end else begin
            sck_m <= link.sck;
            sck_s <= sck_m;
            cs_m <= link.cs_n;
            cs_s <= cs_m;
            si_m <= link.si;
            si_s <= si_m;
            rst_m <= link.rst_n;
            rst_s <= rst_m;
            sck_d <= sck_s;
        end
    end

    assign active = !cs_s && rst_s;
    // A falling edge before the first rise (mode 3) only matters in the data phase
    assign rise = active && (state != D_IDLE) && sck_s && !sck_d;
    assign fall = active && !sck_s && sck_d;
    assign byte_done = rise && (bit_cnt == 3'h7);
    assign in_byte = {shift_in[6:0], si_s};
    assign enter_data = byte_done && (state != D_DATA) && (state != D_SKIP) &&
        ((state == D_OPC && in_byte == OP_ID_RD) ||
         (state == D_ADDR && byte_cnt == 3'h1 && dummy_n == DUMMY_NONE) ||
         (state == D_DUMMY && byte_cnt == 3'h1));
    assign fetch = enter_data || (fall && state == D_DATA && out_cnt == 3'h7);

    // Input shifter, MSB first
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shift_in <= 8'h00;
            bit_cnt <= 3'h0;
        end else if (!active) begin
            bit_cnt <= 3'h0;
        end else if (rise) begin
            shift_in <= in_byte;
            bit_cnt <= 3'(bit_cnt + 1'b1);
        end
    end

    // Command sequencer
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= D_IDLE;
            byte_cnt <= 3'h0;
            dummy_n <= DUMMY_NONE;
            id_mode <= 1'b0;
            user_src_out <= SRC_ARRAY;
            opcode_out <= 8'h00;
            opcode_valid_out <= 1'b0;
        end else begin
            opcode_valid_out <= 1'b0;
            if (!active) begin
                state <= D_IDLE;
            end else if (state == D_IDLE) begin
                state <= D_OPC;
            end else if (byte_done) begin
                unique case (state)
                    D_OPC: begin
                        opcode_out <= in_byte;
                        opcode_valid_out <= 1'b1;
                        byte_cnt <= ADDR_BYTES;
                        id_mode <= 1'b0;
                        dummy_n <= DUMMY_NONE;
                        user_src_out <= SRC_ARRAY;
                        state <= D_ADDR;
                        unique case (in_byte)
                            OP_READ_FAST: dummy_n <= DUMMY_FAST;
                            OP_READ_SLOW: dummy_n <= DUMMY_NONE;
                            OP_READ_LEGACY: dummy_n <= DUMMY_LEGACY;
                            OP_PROT_RD: user_src_out <= SRC_PROT;
                            OP_LOCK_RD: user_src_out <= SRC_LOCK;
                            OP_SEC_RD: user_src_out <= SRC_SEC;
                            OP_ID_RD: begin
                                id_mode <= 1'b1;
                                state <= D_DATA;
                            end
                            default: state <= D_SKIP;
                        endcase
                    end
                    D_ADDR: begin
                        byte_cnt <= 3'(byte_cnt - 1'b1);
                        if (byte_cnt == 3'h1) begin
                            byte_cnt <= dummy_n;
                            state <= (dummy_n == DUMMY_NONE) ? D_DATA : D_DUMMY;
                        end
                    end
                    D_DUMMY: begin
                        byte_cnt <= 3'(byte_cnt - 1'b1);
                        if (byte_cnt == 3'h1) begin
                            state <= D_DATA;
                        end
                    end
                    D_DATA, D_SKIP: state <= state;
                    default: state <= D_SKIP;
                endcase
            end
        end
    end

    // Address register; register and identification reads index from zero
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            user_addr_out <= '0;
        end else if (byte_done && state == D_OPC) begin
            user_addr_out <= '0;
        end else if (byte_done && state == D_ADDR && user_src_out == SRC_ARRAY) begin
            user_addr_out <= {user_addr_out[15:0], in_byte};
        end else if (load) begin
            user_addr_out <= id_mode || user_src_out != SRC_ARRAY ? ADDR_W'(user_addr_out + 1'b1) :
                next_addr(user_addr_out, page_512_out);
        end
    end

    // Byte request to the user side, answered one cycle later
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            user_req_out <= 1'b0;
            load <= 1'b0;
        end else begin
            // The opcode byte that starts an identification read has not yet set id_mode
            user_req_out <= fetch && !id_mode && (state != D_OPC);
            load <= user_req_out || (fetch && (id_mode || state == D_OPC));
        end
    end

    // Output shifter: launched on each falling edge of the data phase
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_shift <= 8'h00;
            out_cnt <= 3'h0;
            so_q <= 1'b1;
        end else if (!active || state != D_DATA) begin
            out_cnt <= 3'h0;
        end else if (load) begin
            out_shift <= id_mode ? id_byte(user_addr_out) : user_data_in;
        end else if (fall) begin
            so_q <= out_shift[7];
            out_shift <= {out_shift[6:0], 1'b0};
            out_cnt <= 3'(out_cnt + 1'b1);
        end
    end

    // SPI modes drive straight away, inside the low phase; full-cycle modes
    // may add a stage of settling, sampled a whole period later by the host
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            so_d <= 1'b1;
            link.so_drv <= 1'b1;
            link.so_oe <= 1'b0;
        end else begin
            so_d <= so_q;
            link.so_drv <= full_cycle_in ? so_d : so_q;
            if (!active) begin
                link.so_oe <= 1'b0;
            end else if (fall && state == D_DATA) begin
                link.so_oe <= 1'b1;
            end
        end
    end

    // Page size: shipped setting at reset, user may select 512 bytes
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            page_512_out <= PAGE512_SHIPPED;
        end else if (set_512_in) begin
            page_512_out <= 1'b1;
        end
    end
endmodule

// File: sfh_host.sv
/*
 * Host end of the serial flash link: serial clock generation, command and
 * read transfers, device reset sequencing and page refresh bookkeeping.
 * Assumes the device answers on the shared output line.
 */
`timescale 1ns/1ps
module sfh_host
    import sfh_pkg::*;
#(
    parameter int HALF_CYC = SCK_HALF_CYC,
    parameter int CW = 16,
    parameter int PTR_W = 8
) (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    sfh_link_if.host link,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic [7:0] opcode_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [2:0] hdr_bytes_in,
    input wire logic [11:0] rd_bytes_in,
    input wire logic mode3_in,
    input wire logic flash_rst_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out,
    output logic busy_out,
    input wire logic pgm_op_in,
    input wire logic refresh_done_in,
    output logic refresh_due_out,
    output logic [PTR_W-1:0] refresh_page_out
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SETUP = 3'b001,
        H_LOW = 3'b011,
        H_HIGH = 3'b010,
        H_GAP = 3'b110,
        H_REST = 3'b100
    } sfh_hst_e;

    sfh_hst_e state;
    logic so_m, so_s, tick, si_pend, mode3_q;
    logic [15:0] div_cnt;
    logic [CW-1:0] rise_cnt, hdr_bits, tot_bits;
    logic [63:0] tx;
    logic [7:0] rx;
    logic [2:0] rx_bit;
    logic [15:0] op_cnt;

    assign tick = (div_cnt == 16'(HALF_CYC - 1));
    assign cmd_ready_out = (state == H_IDLE) && link.rst_n && !flash_rst_in;
    assign busy_out = (state != H_IDLE);

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            so_m <= 1'b1;
            so_s <= 1'b1;
        end else begin
            so_m <= link.so_wire;
            so_s <= so_m;
        end
    end

    // Half-period divider, restarted by each command
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt <= 16'h0000;
        end else if (state == H_IDLE || tick) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= 16'(div_cnt + 1'b1);
        end
    end

    // Device reset is only released while select is high
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            link.rst_n <= 1'b0;
        end else if (flash_rst_in) begin
            link.rst_n <= 1'b0;
        end else if (state == H_IDLE && link.cs_n) begin
            link.rst_n <= 1'b1;
        end
    end

    // Transfer sequencer
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= H_IDLE;
            link.cs_n <= 1'b1;
            link.sck <= 1'b0;
            mode3_q <= 1'b0;
            rise_cnt <= '0;
            hdr_bits <= '0;
            tot_bits <= '0;
        end else begin
            unique case (state)
                H_IDLE: begin
                    link.sck <= mode3_in;
                    if (cmd_valid_in && cmd_ready_out) begin
                        mode3_q <= mode3_in;
                        link.cs_n <= 1'b0;
                        rise_cnt <= '0;
                        hdr_bits <= CW'({hdr_bytes_in, 3'b000}) + CW'(8);
                        tot_bits <= CW'({hdr_bytes_in, 3'b000}) + CW'(8) + CW'({rd_bytes_in, 3'b000});
                        state <= H_SETUP;
                    end
                end
                H_SETUP: if (tick) begin
                    link.sck <= 1'b0;
                    state <= H_LOW;
                end
                H_LOW: if (tick) begin
                    link.sck <= 1'b1;
                    rise_cnt <= CW'(rise_cnt + 1'b1);
                    state <= H_HIGH;
                end
                H_HIGH: if (tick) begin
                    link.sck <= 1'b0;
                    state <= (rise_cnt == tot_bits) ? H_GAP : H_LOW;
                end
                H_GAP: if (tick) begin
                    link.sck <= mode3_q;
                    link.cs_n <= 1'b1;
                    state <= H_REST;
                end
                H_REST: if (tick) begin
                    state <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // Input bits change just after each rising edge, held a full period
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx <= '0;
            link.si <= 1'b0;
            si_pend <= 1'b0;
        end else begin
            si_pend <= (state == H_LOW) && tick;
            if (state == H_IDLE && cmd_valid_in && cmd_ready_out) begin
                tx <= {opcode_in, addr_in, 32'h0000_0000};
                link.si <= opcode_in[7];
            end else if (si_pend) begin
                tx <= {tx[62:0], 1'b0};
                link.si <= tx[62];
            end
        end
    end

    // Output bits are captured at the falling edge after their launch
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx <= 8'h00;
            rx_bit <= 3'h0;
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= 1'b0;
            if (state == H_IDLE) begin
                rx_bit <= 3'h0;
            end else if (state == H_HIGH && tick && rise_cnt > hdr_bits) begin
                rx <= {rx[6:0], so_s};
                rx_bit <= 3'(rx_bit + 1'b1);
                if (rx_bit == 3'h7) begin
                    rd_data_out <= {rx[6:0], so_s};
                    rd_valid_out <= 1'b1;
                end
            end
        end
    end

    // Either programming path counts as one operation; one page falls due
    // per share of the budget so the whole sector is refreshed in time
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            op_cnt <= 16'h0000;
            refresh_due_out <= 1'b0;
            refresh_page_out <= '0;
        end else begin
            if (refresh_done_in) begin
                refresh_page_out <= PTR_W'(refresh_page_out + 1'b1);
            end
            if (pgm_op_in && op_cnt == 16'(OPS_PER_REFRESH - 1)) begin
                op_cnt <= 16'h0000;
                refresh_due_out <= 1'b1;
            end else begin
                if (pgm_op_in) begin
                    op_cnt <= 16'(op_cnt + 1'b1);
                end
                if (refresh_done_in) begin
                    refresh_due_out <= 1'b0;
                end
            end
        end
    end
endmodule

// File: sfh_link_asserts.sv
/*
 * Concurrent checks on the serial flash link signals.
 * Assumes the host runs with a serial clock half period of six core cycles.
 */
`timescale 1ns/1ps
module sfh_link_asserts (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic rst_n,
    input wire logic so_drv,
    input wire logic so_oe,
    input wire logic so_wire
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    logic [15:0] rises;
    logic [3:0] since_fall;
    // Rising clock edges within the current frame
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rises <= 16'h0;
        end else begin
            rises <= cs_n ? 16'h0 : rises + {15'h0, $rose(sck)};
        end
    end
    // Core cycles since the last serial clock fall
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            since_fall <= 4'hF;
        end else if ($fell(sck)) begin
            since_fall <= 4'h1;
        end else if (since_fall != 4'hF) begin
            since_fall <= since_fall + 4'h1;
        end
    end
    a_sel_in_reset: assert property (!rst_n |-> cs_n) else $error("select low while device held in reset");
    a_idle_at_select: assert property ($fell(cs_n) |-> $stable(sck)[*6]) else $error("clock moved at select");
    a_low_half: assert property ($fell(sck) |-> (!sck)[*6]) else $error("clock low phase too short");
    a_high_half: assert property ($rose(sck) |-> sck[*6]) else $error("clock high phase too short");
    a_si_after_rise: assert property ($changed(si) && !cs_n && $past(!cs_n) |-> $past(sck) && !$past(sck, 2))
        else $error("input bit changed away from rising edge");
    a_so_on_fall: assert property ($changed(so_drv) && so_oe && $past(so_oe) |-> since_fall inside {[3:6]})
        else $error("output bit not launched by falling edge");
    a_so_in_low: assert property ($changed(so_drv) && so_oe && $past(so_oe) |-> !sck)
        else $error("output bit changed outside low phase");
    a_so_release: assert property (cs_n[*5] |-> !so_oe) else $error("output driven after deselect");
    a_whole_bytes: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0) else $error("frame not whole bytes");
    c_frame: cover property ($rose(cs_n) && rises > 16'h20);
    c_mode3: cover property ($fell(cs_n) && sck);
    c_drive: cover property (so_oe && !cs_n);
    c_low_bit: cover property (so_oe && !so_wire);
endmodule

// File: tb_top.sv
/*
 * Bench joining host and device ends over one link.
 * Assumes the host half period parameter is shortened to six core cycles.
 */
`timescale 1ns/1ps
module tb_top
    import sfh_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic fc = 1'b0, s512 = 1'b0, req, p512_o, opv, cv = 1'b0, rdy, rdv, busy, m3 = 1'b0, frst = 1'b0;
    logic pgm = 1'b0, rdone = 1'b0, due, p512 = 1'b0;
    logic [7:0] udata = 8'h00, op_o, op_i = 8'h00, rdd, last_op = 8'h00;
    logic [23:0] uaddr, ad = 24'h0;
    logic [2:0] hb = 3'h0;
    logic [11:0] nb = 12'h0;
    logic [7:0] rpage;
    sfh_src_e usrc;
    int err_total = 0, checks = 0;
    localparam logic [31:0] ID_BYTES_T = 32'h5A01_0200;
    always #2.5 clk = ~clk;
    sfh_link_if u_sfh_link_if();
    sfh_dev u_sfh_dev (.core_clk_in(clk), .nrst_in(nrst), .link(u_sfh_link_if), .full_cycle_in(fc),
        .set_512_in(s512), .user_data_in(udata), .user_req_out(req), .user_src_out(usrc),
        .user_addr_out(uaddr), .page_512_out(p512_o), .opcode_out(op_o), .opcode_valid_out(opv));
    sfh_host #(.HALF_CYC(6)) u_sfh_host (.core_clk_in(clk), .nrst_in(nrst), .link(u_sfh_link_if),
        .cmd_valid_in(cv), .cmd_ready_out(rdy), .opcode_in(op_i), .addr_in(ad), .hdr_bytes_in(hb),
        .rd_bytes_in(nb), .mode3_in(m3), .flash_rst_in(frst), .rd_data_out(rdd), .rd_valid_out(rdv),
        .busy_out(busy), .pgm_op_in(pgm), .refresh_done_in(rdone), .refresh_due_out(due),
        .refresh_page_out(rpage));
    sfh_link_asserts u_sfh_link_asserts (.core_clk_in(clk), .nrst_in(nrst), .sck(u_sfh_link_if.sck),
        .cs_n(u_sfh_link_if.cs_n), .si(u_sfh_link_if.si), .rst_n(u_sfh_link_if.rst_n),
        .so_drv(u_sfh_link_if.so_drv), .so_oe(u_sfh_link_if.so_oe), .so_wire(u_sfh_link_if.so_wire));
    function automatic logic [7:0] ef(input sfh_src_e s, input logic [23:0] a);
        return {s, a[10], a[4:0]} ^ 8'hA5;
    endfunction
    function automatic logic [23:0] nxt(input logic [23:0] a);
        return (p512 || a[9:0] != PAGE_LAST_LONG) ? a + 24'h1 : {a[23:10] + 14'h1, 10'h0};
    endfunction
    // User side of the device answers each byte request one cycle later
    always @(posedge clk) begin
        if (req === 1'b1) udata <= #1 ef(usrc, uaddr);
        if (opv === 1'b1) last_op <= op_o;
    end
    task automatic final_report();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        checks++;
        if (v !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, v);
        end
    endtask
    task automatic waitfor(ref logic sig);
        int k;
        k = 0;
        while (sig !== 1'b1 && k < 3000) begin
            @(posedge clk); #1;
            k++;
        end
        if (sig !== 1'b1) begin
            chk("wait bound", 0, 1);
            final_report();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [2:0] h, input int n,
        input sfh_src_e s);
        logic [7:0] e;
        logic [23:0] p;
        p = (s == SRC_ARRAY) ? a : 24'h0;
        op_i = op; ad = a; hb = h; nb = n[11:0]; cv = 1'b1;
        waitfor(rdy);
        cyc(1);
        cv = 1'b0;
        for (int i = 0; i < n; i++) begin
            waitfor(rdv);
            if (op == OP_ID_RD) e = ID_BYTES_T[31 - 8 * i -: 8];
            else if (op == 8'h55) e = 8'hFF;
            else e = ef(s, p);
            chk("read byte", {24'h0, e}, {24'h0, rdd});
            p = (s == SRC_ARRAY) ? nxt(p) : p + 24'h1;
            cyc(1);
        end
        for (int k = 0; k < 3000 && busy !== 1'b0; k++) cyc(1);
        if (busy !== 1'b0) begin
            chk("busy bound", 0, 1);
            final_report();
        end
        cyc(4);
        chk("opcode", {24'h0, op}, {24'h0, last_op});
    endtask
    initial begin
        cyc(6);
        nrst = 1'b1;
        cyc(3);
        chk("page 512 at reset", 0, {31'h0, p512_o});
        frst = 1'b1;
        cyc(4);
        chk("ready in flash reset", 0, {31'h0, rdy});
        chk("select in flash reset", 1, {31'h0, u_sfh_link_if.cs_n});
        frst = 1'b0;
        cyc(6);
        for (int m = 0; m < 4; m++) begin
            m3 = m[0]; fc = m[1];
            cyc(2);
            xfer(OP_READ_FAST, 24'h00C20F, 3'h4, 2, SRC_ARRAY);
            xfer(OP_READ_SLOW, 24'h012345, 3'h3, 3, SRC_ARRAY);
            xfer(OP_READ_LEGACY, 24'h000410, 3'h7, 2, SRC_ARRAY);
            xfer(OP_PROT_RD, 24'h0, 3'h3, 2, SRC_PROT);
            xfer(OP_LOCK_RD, 24'h0, 3'h3, 2, SRC_LOCK);
            xfer(OP_SEC_RD, 24'h0, 3'h3, 3, SRC_SEC);
            xfer(OP_ID_RD, 24'h0, 3'h0, 4, SRC_ARRAY);
            xfer(8'h55, 24'h0, 3'h0, 1, SRC_ARRAY);
        end
        s512 = 1'b1;
        cyc(1);
        s512 = 1'b0;
        p512 = 1'b1;
        cyc(2);
        chk("page 512 set", 1, {31'h0, p512_o});
        xfer(OP_READ_FAST, 24'h00C20F, 3'h4, 2, SRC_ARRAY);
        for (int i = 0; i < OPS_PER_REFRESH; i++) begin
            if (i == OPS_PER_REFRESH - 1) chk("due early", 0, {31'h0, due});
            pgm = 1'b1;
            cyc(1);
            pgm = 1'b0;
            cyc(1);
        end
        chk("due", 1, {31'h0, due});
        chk("pointer", 0, {24'h0, rpage});
        rdone = 1'b1;
        cyc(1);
        rdone = 1'b0;
        cyc(2);
        chk("due cleared", 0, {31'h0, due});
        chk("pointer next", 1, {24'h0, rpage});
        final_report();
    end
endmodule
